/* File: hw/lfh_top.sv */
/*
 * Current-limit lock fault handler: deglitches the lock detector, applies the
 * configured response to the half-bridge gate controls and the fault indicator.
 * Assumes one AHB-Lite master, synchronous inputs and a 25 MHz hclk.
 */
module lfh_top
   import lfh_pkg::*;
#(
   parameter int unsigned RETRY_RESET_CYC = RETRY_INTERVAL_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic current_limit_hit,
   input wire logic [2:0] pwm_high_on,
   input wire logic [2:0] pwm_low_on,
   output logic [2:0] gate_high_on,
   output logic [2:0] gate_low_on,
   output logic gate_hiz,
   output logic fault_indicator_n,
   output logic [2:0] no_motor_current_threshold,
   output logic irq
);

   logic [31:0] cfg_r;
   logic [RETRY_TMR_W-1:0] retry_int_r;
   logic [N_EVENTS-1:0] status_r;
   logic [N_EVENTS-1:0] mask_r;
   logic [N_EVENTS-1:0] evt;
   logic wr_pend_r;
   logic [11:0] wr_addr_r;
   logic clear_req;
   lfh_state_e state_r;
   lfh_act_e act_r;
   logic [4:0] retry_cnt_r;
   logic [RETRY_TMR_W-1:0] retry_tmr_r;
   logic filt_det;
   logic [FILT_CNT_W-1:0] filt_len;
   logic [3:0] mode;
   logic [4:0] limit;
   logic [31:0] rd_val;

   assign mode = cfg_r[MODE_LSB +: 4];
   assign limit = lfh_retry_limit(cfg_r[LIMIT_LSB +: 3]);
   assign filt_len = FILT_CNT_W'(cfg_r[FILT_LSB +: 3] * FILT_STEP_CYC);
   assign clear_req = wr_pend_r && (wr_addr_r == ADDR_CTRL) && hwdata[CTRL_CLEAR_BIT];

   // ==========================================================
   // AHB-Lite slave: zero wait states, always OKAY
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
      end else begin
         wr_pend_r <= hsel && hready && htrans[1] && hwrite;
         wr_addr_r <= haddr[11:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_comb begin
      case (haddr[11:0])
         ADDR_CFG: rd_val = cfg_r;
         ADDR_RETRY: rd_val = 32'(retry_int_r);
         ADDR_STATUS: rd_val = 32'(status_r);
         ADDR_MASK: rd_val = 32'(mask_r);
         ADDR_STATE: rd_val = {22'h0, filt_det, retry_cnt_r, act_r, state_r};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // Read data are sampled in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hsel && hready && htrans[1] && !hwrite) begin
         hrdata <= rd_val;
      end else begin
         hrdata <= 32'h0000_0000;
      end
   end

   // ==========================================================
   // Configuration registers
   // ==========================================================
   // response field writable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_r <= CFG_RESET;
      end else if (wr_pend_r && wr_addr_r == ADDR_CFG) begin
         cfg_r <= hwdata & CFG_WMASK;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         retry_int_r <= RETRY_TMR_W'(RETRY_RESET_CYC);
      end else if (wr_pend_r && wr_addr_r == ADDR_RETRY) begin
         retry_int_r <= hwdata[RETRY_TMR_W-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_r <= EVT_RESET;
      end else if (wr_pend_r && wr_addr_r == ADDR_MASK) begin
         mask_r <= hwdata[N_EVENTS-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         no_motor_current_threshold <= 3'h0;
      end else begin
         no_motor_current_threshold <= cfg_r[THR_LSB +: 3];
      end
   end

   lfh_filter #(
      .CNT_W(FILT_CNT_W)
   ) u_filter (
      .hclk(hclk),
      .hresetn(hresetn),
      .len(filt_len),
      .raw(current_limit_hit),
      .det(filt_det)
   );

   // ==========================================================
   // Lock response state machine
   // ==========================================================
   // codes 9h-Fh raise no event
   always_comb begin
      evt = '0;
      if (state_r == ST_IDLE && filt_det) begin
         if (mode < 4'h4) begin
            evt[ST_LATCH_BIT] = 1'b1;
         end else if (mode < MODE_REPORT) begin
            if (limit != 5'h00 && retry_cnt_r >= limit) begin
               evt[ST_EXHAUST_BIT] = 1'b1;
            end else begin
               evt[ST_RETRY_BIT] = 1'b1;
            end
         end else if (mode == MODE_REPORT) begin
            evt[ST_REPORT_BIT] = 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= ST_IDLE;
         act_r <= ACT_NONE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (evt[ST_LATCH_BIT] || evt[ST_EXHAUST_BIT]) begin
                  state_r <= ST_LATCHED;
                  act_r <= lfh_mode_act(mode);
               end else if (evt[ST_RETRY_BIT]) begin
                  state_r <= ST_RETRY;
                  act_r <= lfh_mode_act(mode);
               end
            end
            ST_RETRY: begin
               if (retry_tmr_r == '0) begin
                  state_r <= ST_IDLE;
                  act_r <= ACT_NONE;
               end
            end
            ST_LATCHED: begin
               if (clear_req) begin
                  state_r <= ST_IDLE;
                  act_r <= ACT_NONE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               act_r <= ACT_NONE;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         retry_tmr_r <= '0;
      end else if (evt[ST_RETRY_BIT]) begin
         retry_tmr_r <= retry_int_r;
      end else if (state_r == ST_RETRY && retry_tmr_r != '0) begin
         retry_tmr_r <= retry_tmr_r - 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         retry_cnt_r <= 5'h00;
      end else if (clear_req) begin
         retry_cnt_r <= 5'h00;
      end else if (evt[ST_RETRY_BIT] && retry_cnt_r != 5'h1F) begin
         retry_cnt_r <= retry_cnt_r + 1'b1;
      end
   end

   // ==========================================================
   // Gate controls and fault indicator
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_high_on <= 3'h0;
         gate_low_on <= 3'h0;
         gate_hiz <= 1'b0;
      end else begin
         case (act_r)
            ACT_HIZ: begin
               gate_high_on <= 3'h0;
               gate_low_on <= 3'h0;
               gate_hiz <= 1'b1;
            end
            ACT_HS_BRAKE: begin
               gate_high_on <= 3'h7;
               gate_low_on <= 3'h0;
               gate_hiz <= 1'b0;
            end
            ACT_LS_BRAKE: begin
               gate_high_on <= 3'h0;
               gate_low_on <= 3'h7;
               gate_hiz <= 1'b0;
            end
            default: begin
               gate_high_on <= pwm_high_on;
               gate_low_on <= pwm_low_on;
               gate_hiz <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fault_indicator_n <= 1'b1;
      end else begin
         fault_indicator_n <= (state_r == ST_IDLE);
      end
   end

   // ==========================================================
   // Event status and interrupt
   // ==========================================================
   // report sets status
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_r <= EVT_RESET;
      end else if (wr_pend_r && wr_addr_r == ADDR_STATUS) begin
         status_r <= (status_r & ~hwdata[N_EVENTS-1:0]) | evt;
      end else begin
         status_r <= status_r | evt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_r & mask_r);
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_thr;
      1 |=> no_motor_current_threshold == $past(cfg_r[THR_LSB +: 3]);
   endproperty
   a_thr: assert property (p_thr) else $error("threshold code not forwarded");

   property p_mode_wr;
      wr_pend_r && wr_addr_r == ADDR_CFG |=> mode == $past(hwdata[MODE_LSB +: 4]);
   endproperty
   a_mode_wr: assert property (p_mode_wr) else $error("response code not stored");

   property p_latch_hiz;
      state_r == ST_IDLE && filt_det && mode <= 4'h1 |=> state_r == ST_LATCHED ##1 gate_hiz && !fault_indicator_n;
   endproperty
   a_latch_hiz: assert property (p_latch_hiz) else $error("tristate latch missing");

   property p_latch_hsb;
      state_r == ST_IDLE && filt_det && mode == 4'h2 |=> ##1 gate_high_on == 3'h7 && gate_low_on == 3'h0;
   endproperty
   a_latch_hsb: assert property (p_latch_hsb) else $error("high-side brake missing");

   property p_latch_lsb;
      state_r == ST_IDLE && filt_det && mode == 4'h3 |=> ##1 gate_low_on == 3'h7 && gate_high_on == 3'h0;
   endproperty
   a_latch_lsb: assert property (p_latch_lsb) else $error("low-side brake missing");

   property p_retry_end;
      state_r == ST_RETRY && retry_tmr_r == '0 |=> state_r == ST_IDLE ##1 fault_indicator_n;
   endproperty
   a_retry_end: assert property (p_retry_end) else $error("retry did not clear");

   property p_exhaust;
      state_r == ST_IDLE && filt_det && mode[3:2] == 2'b01 && limit != 5'h00 && retry_cnt_r >= limit
         |=> state_r == ST_LATCHED;
   endproperty
   a_exhaust: assert property (p_exhaust) else $error("retry limit not latched");

   property p_retry_act;
      state_r == ST_IDLE && filt_det && mode == 4'h6 && evt[ST_RETRY_BIT] |=> state_r == ST_RETRY && act_r == ACT_HS_BRAKE;
   endproperty
   a_retry_act: assert property (p_retry_act) else $error("retry output state wrong");

   property p_report;
      state_r == ST_IDLE && filt_det && mode == MODE_REPORT |=> state_r == ST_IDLE && status_r[ST_REPORT_BIT];
   endproperty
   a_report: assert property (p_report) else $error("report mode acted");

   property p_disabled;
      state_r == ST_IDLE && mode >= MODE_DISABLE_MIN |-> evt == '0;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled mode reacted");

   property p_hold;
      state_r == ST_LATCHED && !clear_req |=> state_r == ST_LATCHED;
   endproperty
   a_hold: assert property (p_hold) else $error("latched fault released");

   c_latch: cover property (state_r == ST_IDLE ##1 state_r == ST_LATCHED);
   c_retry: cover property (state_r == ST_RETRY ##1 state_r == ST_IDLE);
   c_report: cover property ($rose(status_r[ST_REPORT_BIT]));
   c_irq: cover property ($rose(irq));

endmodule : lfh_top

/* File: common/lfh_pkg.sv */
/*
 * Constants, types and helper functions of the current-limit lock fault handler.
 * Assumes a single 25 MHz clock; the register map is reached over AHB-Lite.
 */
package lfh_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int unsigned CLK_MHZ = 25;
   localparam int unsigned FILT_STEP_NS = 1000;
   localparam int unsigned FILT_STEP_CYC = (FILT_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RETRY_INTERVAL_US = 1000;
   localparam int unsigned RETRY_INTERVAL_CYC = RETRY_INTERVAL_US * CLK_MHZ;
   localparam int unsigned FILT_CNT_W = 8;
   localparam int unsigned RETRY_TMR_W = 24;

   // ==========================================================
   // Register map (byte addresses, low 12 bits decoded)
   // ==========================================================
   localparam logic [11:0] CFG_IDX = 12'h092;
   localparam logic [11:0] ADDR_CFG = 12'(CFG_IDX * 4);
   localparam logic [11:0] ADDR_CTRL = 12'h250;
   localparam logic [11:0] ADDR_RETRY = 12'h254;
   localparam logic [11:0] ADDR_STATUS = 12'h258;
   localparam logic [11:0] ADDR_MASK = 12'h25C;
   localparam logic [11:0] ADDR_STATE = 12'h260;

   // ==========================================================
   // Fields and reset values
   // ==========================================================
   localparam int unsigned THR_LSB = 19;
   localparam int unsigned MODE_LSB = 15;
   localparam int unsigned FILT_LSB = 12;
   localparam int unsigned LIMIT_LSB = 0;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] CFG_WMASK = 32'h7FFF_F7FF;
   localparam int unsigned CTRL_CLEAR_BIT = 0;
   localparam logic [3:0] MODE_REPORT = 4'h8;
   localparam logic [3:0] MODE_DISABLE_MIN = 4'h9;

   localparam int unsigned ST_LATCH_BIT = 0;
   localparam int unsigned ST_RETRY_BIT = 1;
   localparam int unsigned ST_REPORT_BIT = 2;
   localparam int unsigned ST_EXHAUST_BIT = 3;
   localparam int unsigned N_EVENTS = 4;
   localparam logic [N_EVENTS-1:0] EVT_RESET = 4'h0;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RETRY = 2'b01,
      ST_LATCHED = 2'b11
   } lfh_state_e;

   typedef enum logic [1:0] {
      ACT_NONE = 2'b00,
      ACT_HIZ = 2'b01,
      ACT_HS_BRAKE = 2'b10,
      ACT_LS_BRAKE = 2'b11
   } lfh_act_e;

   // Retry limit code to count; zero means no limit
   function automatic logic [4:0] lfh_retry_limit(input logic [2:0] code);
      case (code)
         3'h1: lfh_retry_limit = 5'h02;
         3'h2: lfh_retry_limit = 5'h03;
         3'h3: lfh_retry_limit = 5'h05;
         3'h4: lfh_retry_limit = 5'h07;
         3'h5: lfh_retry_limit = 5'h0A;
         3'h6: lfh_retry_limit = 5'h0F;
         3'h7: lfh_retry_limit = 5'h14;
         default: lfh_retry_limit = 5'h00;
      endcase
   endfunction : lfh_retry_limit

   // Output state of the half-bridges for a response code 0h..7h
   function automatic lfh_act_e lfh_mode_act(input logic [3:0] mode);
      case (mode[1:0])
         2'h2: lfh_mode_act = ACT_HS_BRAKE;
         2'h3: lfh_mode_act = ACT_LS_BRAKE;
         default: lfh_mode_act = ACT_HIZ;
      endcase
   endfunction : lfh_mode_act

endpackage : lfh_pkg

/* File: hw/lfh_filter.sv */
/*
 * Deglitch filter for the current-limit lock detector.
 * Assumes the raw detector level is synchronous to hclk.
 */
module lfh_filter
   import lfh_pkg::*;
#(
   parameter int unsigned CNT_W = FILT_CNT_W
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [CNT_W-1:0] len,
   input wire logic raw,
   output logic det
);

   logic [CNT_W-1:0] cnt_r;

   // ==========================================================
   // Consecutive-high counter
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '0;
      end else if (!raw) begin
         cnt_r <= '0;
      end else if (cnt_r < len) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         det <= 1'b0;
      end else begin
         det <= raw && (cnt_r >= len);
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_filt_hold;
      $rose(det) |-> $past(raw) && ($past(cnt_r) >= $past(len));
   endproperty
   a_filt_hold: assert property (p_filt_hold) else $error("filter released early");

endmodule : lfh_filter

/* File: tb/lfh_stage_model.sv */
/*
 * Behavioural model of the three-phase power stage that the handler drives.
 * Assumes the bench raises overload to make a driven bridge exceed its limit.
 */
module lfh_stage_model (
   input wire logic overload,
   input wire logic [2:0] gate_high_on,
   input wire logic [2:0] gate_low_on,
   input wire logic gate_hiz,
   output logic current_limit_hit
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Current path
   // ==========================================================
   // Current only flows while some transistor conducts and the bridge is not tristated
   assign current_limit_hit = overload & ~gate_hiz & ((|gate_high_on) | (|gate_low_on));
endmodule : lfh_stage_model

/* File: tb/current_limit_lock_fault_handler_test.sv */
/*
 * Self-checking bench of the lock fault handler: AHB-Lite master, power stage
 * model, expected-value queue and output monitor.
 * Assumes lfh_pkg and a retry interval shortened to 20 cycles.
 */
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module current_limit_lock_fault_handler_test
   import lfh_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, hready, overload, obs_req;
   logic [1:0] htrans, obs_sel;
   logic [2:0] hsize, pwm_hi, pwm_lo, gate_high_on, gate_low_on, no_motor_current_threshold;
   logic [31:0] haddr, hwdata, hrdata, got, exp_v;
   logic hreadyout, hresp, current_limit_hit, gate_hiz, fault_indicator_n, irq, fn_q;
   logic [7:0] seed;
   logic [11:0] pins;
   logic [31:0] exp_q[$];
   int n_mismatch = 0;
   int checks_done = 0;
   int n_rise = 0;
   int rise_base = 0;
   assign hready = hreadyout;
   assign pins = {no_motor_current_threshold, irq, fault_indicator_n, gate_hiz, gate_high_on, gate_low_on};
   // ==========================================================
   // Design and power stage
   // ==========================================================
   lfh_top #(.RETRY_RESET_CYC(20)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .current_limit_hit(current_limit_hit), .pwm_high_on(pwm_hi),
      .pwm_low_on(pwm_lo), .gate_high_on(gate_high_on), .gate_low_on(gate_low_on), .gate_hiz(gate_hiz),
      .fault_indicator_n(fault_indicator_n), .no_motor_current_threshold(no_motor_current_threshold),
      .irq(irq));
   lfh_stage_model stage (.overload(overload), .gate_high_on(gate_high_on), .gate_low_on(gate_low_on),
      .gate_hiz(gate_hiz), .current_limit_hit(current_limit_hit));
   // ==========================================================
   // Clock, monitor, watchdog
   // ==========================================================
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      fn_q <= fault_indicator_n;
      if (fault_indicator_n === 1'b1 && fn_q === 1'b0) n_rise++;
      if (obs_req && (obs_sel != 2'h0 || hreadyout)) begin
         got = (obs_sel == 2'h0) ? hrdata : (obs_sel == 2'h1) ? {20'h0, pins} : 32'(n_rise - rise_base);
         exp_v = exp_q.pop_front();
         `CHK(got, exp_v)
      end
      if (obs_req && obs_sel == 2'h0 && hreadyout) `CHK(hresp, 1'b0)
   end
   initial begin
      #800000;
      n_mismatch++;
      give_verdict();
   end
   // ==========================================================
   // Helpers
   // ==========================================================
   task automatic give_verdict;
      if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   function automatic logic [31:0] cfg(input int m, input int f, input int l, input int t);
      return (32'(t) << THR_LSB) | (32'(m) << MODE_LSB) | (32'(f) << FILT_LSB) | (32'(l) << LIMIT_LSB);
   endfunction : cfg
   function automatic lfh_act_e mode_act(input int m);
      return (m % 4 == 2) ? ACT_HS_BRAKE : (m % 4 == 3) ? ACT_LS_BRAKE : ACT_HIZ;
   endfunction : mode_act
   function automatic logic [31:0] ep(input lfh_act_e a, input logic fn, input logic iq, input int t);
      logic [2:0] hi;
      logic [2:0] lo;
      hi = (a == ACT_HS_BRAKE) ? 3'h7 : (a == ACT_NONE) ? pwm_hi : 3'h0;
      lo = (a == ACT_LS_BRAKE) ? 3'h7 : (a == ACT_NONE) ? pwm_lo : 3'h0;
      return {20'h0, 3'(t), iq, fn, a == ACT_HIZ, hi, lo};
   endfunction : ep
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc
   task automatic new_pwm;
      seed = lfsr(seed);
      pwm_hi <= seed[2:0] | 3'h1;
      pwm_lo <= seed[5:3];
   endtask : new_pwm
   task automatic addr_phase(input logic [11:0] a, input logic w);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
   endtask : addr_phase
   task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
      addr_phase(a, 1'b1);
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask : bus_wr
   task automatic observe(input logic [1:0] sel, input logic [31:0] e);
      exp_q.push_back(e);
      obs_sel <= sel;
      obs_req <= 1'b1;
      do @(posedge hclk); while (sel == 2'h0 && hreadyout !== 1'b1);
      obs_req <= 1'b0;
      @(posedge hclk);
   endtask : observe
   task automatic bus_rd(input logic [11:0] a, input logic [31:0] e);
      addr_phase(a, 1'b0);
      observe(2'h0, e);
   endtask : bus_rd
   task automatic clr_all;
      bus_wr(ADDR_CTRL, 32'h0000_0001);
      bus_wr(ADDR_STATUS, 32'h0000_000F);
      cyc(3);
   endtask : clr_all
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      overload = 1'b0;
      pwm_hi = 3'h0;
      pwm_lo = 3'h0;
      obs_req = 1'b0;
      obs_sel = 2'h0;
      fn_q = 1'b1;
      seed = 8'h5E;
      cyc(8);
      hresetn <= 1'b1;
      @(posedge hclk);
      observe(2'h1, ep(ACT_NONE, 1'b1, 1'b0, 0));
      bus_rd(ADDR_CFG, CFG_RESET);
      bus_rd(ADDR_RETRY, 32'h0000_0014);
      bus_wr(ADDR_CFG, 32'hFFFF_FFFF);
      bus_rd(ADDR_CFG, CFG_WMASK);
      observe(2'h1, ep(ACT_NONE, 1'b1, 1'b0, 7));
      bus_rd(12'h300, 32'h0);
      bus_wr(ADDR_MASK, 32'h0000_000F);
      for (int m = 0; m < 4; m++) begin
         new_pwm();
         bus_wr(ADDR_CFG, cfg(m, 0, 0, m));
         overload <= 1'b1;
         cyc(6);
         observe(2'h1, ep(mode_act(m), 1'b0, 1'b1, m));
         bus_rd(ADDR_STATUS, 32'h0000_0001);
         overload <= 1'b0;
         cyc(40);
         observe(2'h1, ep(mode_act(m), 1'b0, 1'b1, m));
         clr_all();
         observe(2'h1, ep(ACT_NONE, 1'b1, 1'b0, m));
      end
      bus_wr(ADDR_MASK, 32'h0);
      bus_wr(ADDR_CFG, cfg(8, 0, 0, 0));
      overload <= 1'b1;
      cyc(6);
      observe(2'h1, ep(ACT_NONE, 1'b1, 1'b0, 0));
      bus_rd(ADDR_STATUS, 32'h0000_0004);
      bus_wr(ADDR_MASK, 32'h0000_000F);
      overload <= 1'b0;
      cyc(3);
      observe(2'h1, ep(ACT_NONE, 1'b1, 1'b1, 0));
      clr_all();
      observe(2'h1, ep(ACT_NONE, 1'b1, 1'b0, 0));
      bus_wr(ADDR_CFG, cfg(8, 1, 0, 0));
      overload <= 1'b1;
      cyc(20);
      overload <= 1'b0;
      cyc(4);
      bus_rd(ADDR_STATUS, 32'h0);
      overload <= 1'b1;
      cyc(30);
      overload <= 1'b0;
      bus_rd(ADDR_STATUS, 32'h0000_0004);
      clr_all();
      for (int m = 9; m < 16; m++) begin
         bus_wr(ADDR_CFG, cfg(m, 0, 0, m % 8));
         overload <= 1'b1;
         cyc(6);
         observe(2'h1, ep(ACT_NONE, 1'b1, 1'b0, m % 8));
         bus_rd(ADDR_STATUS, 32'h0);
         overload <= 1'b0;
      end
      bus_wr(ADDR_CFG, cfg(4, 0, 0, 0));
      overload <= 1'b1;
      cyc(2);
      overload <= 1'b0;
      cyc(3);
      observe(2'h1, ep(ACT_HIZ, 1'b0, 1'b1, 0));
      cyc(30);
      observe(2'h1, ep(ACT_NONE, 1'b1, 1'b1, 0));
      clr_all();
      for (int m = 4; m < 8; m++) begin
         new_pwm();
         bus_wr(ADDR_CFG, cfg(m, 0, 1, 0));
         rise_base = n_rise;
         overload <= 1'b1;
         cyc(150);
         overload <= 1'b0;
         cyc(60);
         observe(2'h1, ep(mode_act(m), 1'b0, 1'b1, 0));
         observe(2'h2, 32'h2);
         bus_rd(ADDR_STATE, 32'h0000_0023 | (32'(mode_act(m)) << 2));
         clr_all();
         observe(2'h1, ep(ACT_NONE, 1'b1, 1'b0, 0));
      end
      give_verdict();
   end
endmodule : current_limit_lock_fault_handler_test
